// File: lsd_pkg.sv
`default_nettype none
package lsd_pkg;
  // register window: global address = base + offset
  localparam logic [15:0] LSD_BASE_BLOCKING    = 16'h0200;
  localparam logic [15:0] LSD_BASE_NONBLOCKING = 16'h0300;
  localparam logic [15:0] LSD_BASE_MASK        = 16'hff00;
  localparam logic [7:0]  LSD_OFF_CTRL         = 8'h30;
  localparam logic [7:0]  LSD_OFF_STATUS       = 8'h31;
  localparam logic [7:0]  LSD_OFF_KEY          = 8'h32;
  // reset values and writable bits
  localparam logic [7:0]  LSD_CTRL_RST         = 8'h00;
  localparam logic [7:0]  LSD_CTRL_WMASK       = 8'hbf;
  localparam logic [3:0]  LSD_KEY_RST          = 4'h0;
  localparam logic [3:0]  LSD_KEY_UNLOCK       = 4'h5;
  localparam logic [7:0]  LSD_RDATA_RST        = 8'h00;
  // control register field positions
  localparam int          LSD_BIT_OT_IE        = 7;
  localparam int          LSD_BIT_SEL_TWO      = 5;
  localparam int          LSD_BIT_SEL_ONE      = 4;
  localparam int          LSD_BIT_GATE_TWO     = 3;
  localparam int          LSD_BIT_GATE_ONE     = 2;
  localparam int          LSD_BIT_ON_TWO       = 1;
  localparam int          LSD_BIT_ON_ONE       = 0;
  // status register field positions
  localparam int          LSD_BIT_OT_PRESENT   = 7;
  // synchroniser width: overtemp, 2 x current limit, 2 x open load, 2 x overvoltage
  localparam int          LSD_SYNC_W           = 7;
endpackage
`default_nettype wire

// File: lsd_chan_if.sv
`default_nettype none
// per-driver control from the register block to one output stage
interface lsd_chan_if;
  logic on;
  logic gate;
  logic sel;
  logic permit;
  logic drive;
  modport ctl  (output on, output gate, output sel, output permit, input drive);
  modport chan (input on, input gate, input sel, input permit, output drive);
endinterface
`default_nettype wire

// File: lsd_sync.sv
`default_nettype none
module lsd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] stage_reg;
  logic [W-1:0] stage_next;

  // first stage feeds only the second, nothing else looks at it
  always_comb begin
    meta_next  = pin_i;
    stage_next = meta_reg;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta_reg  <= '0;
      stage_reg <= '0;
    end else begin
      meta_reg  <= meta_next;
      stage_reg <= stage_next;
    end
  end

  assign sync_o = stage_reg;
endmodule
`default_nettype wire

// File: lsd_channel.sv
`default_nettype none
module lsd_channel (
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic pwm_ch0_i,
  input  wire logic pwm_ch1_i,
  lsd_chan_if.chan  ch
);
  logic drive_reg;
  logic drive_next;
  logic wave;

  // pick the pwm source, then modulate only when gating is on
  always_comb begin
    wave       = ch.sel ? pwm_ch1_i : pwm_ch0_i;
    drive_next = ch.permit & ch.on & (ch.gate ? wave : 1'b1);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign ch.drive = drive_reg;
endmodule
`default_nettype wire

// File: lsd_top.sv
// Functional notes
// - overtemp interrupt enable is control bit 7
// - bits 5/4 pick pwm channel 1, else 0
// - bits 3/2 modulate driver with chosen pwm
// - bits 1/0 switch drivers once unlocked
// - key field 0x5 unlocks, anything else locks
// - status bit 7 overtemp; status read clears flag
// - status bits 3/2 show current limitation
// - status bits 1/0 show open load
// - open load hidden while driver is off
// - overvoltage shuts drivers, clears driver bits 1/0
// - overvoltage flag follows condition; irq if enabled
// - flag read clears irq; rearms on reappearance
// - overtemp stops drivers, latches low-side source
// - irq request only when low-side mask set
// - control write re-enables after overtemp gone
// - decode offsets at bases 0x0200 and 0x300
// - drivers only active in normal mode
// - control 0x30, key 0x32, control resets zero
`default_nettype none
module lsd_top (
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_i,
  // register bus, same clock domain
  input  wire logic                  bus_sel_i,
  input  wire logic                  bus_wr_i,
  input  wire logic [15:0]           bus_addr_i,
  input  wire logic [7:0]            bus_wdata_i,
  output logic      [7:0]            bus_rdata_o,
  output logic                       bus_ack_o,
  // system and pwm, same clock domain
  input  wire logic                  normal_mode_i,
  input  wire logic                  pwm_ch0_i,
  input  wire logic                  pwm_ch1_i,
  input  wire logic                  regulator_overvoltage_irq_enable_i,
  input  wire logic                  ov_flag_read_i,
  input  wire logic                  low_side_irq_mask_i,
  // analog sense lines, asynchronous
  input  wire logic                  overtemp_pin_i,
  input  wire logic [1:0]            current_limit_pin_i,
  input  wire logic [1:0]            open_load_pin_i,
  input  wire logic [1:0]            overvolt_pin_i,
  // outputs
  output logic      [1:0]            drv_on_o,
  output logic                       regulator_overvoltage_flag_o,
  output logic                       ov_irq_o,
  output logic                       overtemp_irq_flag_o,
  output logic                       irq_o
);
  import lsd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [LSD_SYNC_W-1:0] sync_bus;
  logic                  ot_now;
  logic [1:0]            cl_now;
  logic [1:0]            ol_now;
  logic                  ov_now;
  logic [7:0]            ctrl_reg;
  logic [7:0]            ctrl_next;
  logic [3:0]            key_reg;
  logic [3:0]            key_next;
  logic                  ot_shut_reg;
  logic                  ot_shut_next;
  logic                  ot_flag_reg;
  logic                  ot_flag_next;
  logic                  ov_irq_reg;
  logic                  ov_irq_next;
  logic                  ot_prev_reg;
  logic                  ov_prev_reg;
  logic [7:0]            rdata_reg;
  logic [7:0]            rdata_next;
  logic                  ack_reg;
  logic                  hit;
  logic [7:0]            off;
  logic                  wr_ctrl;
  logic                  wr_key;
  logic                  rd_status;
  logic                  ot_rise;
  logic                  ov_rise;
  logic                  unlocked;
  logic                  permit;
  logic [1:0]            drive;
  logic [7:0]            status;

  lsd_chan_if ch_one ();
  lsd_chan_if ch_two ();

  // either base maps the same three registers
  function automatic logic in_window(input logic [15:0] a);
    in_window = ((a & LSD_BASE_MASK) == LSD_BASE_BLOCKING) ||
                ((a & LSD_BASE_MASK) == LSD_BASE_NONBLOCKING);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // analog flags come from another supply domain
  lsd_sync #(.W(LSD_SYNC_W)) u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .pin_i     ({overvolt_pin_i, open_load_pin_i, current_limit_pin_i, overtemp_pin_i}),
    .sync_o    (sync_bus)
  );

  assign ot_now = sync_bus[0];
  assign cl_now = sync_bus[2:1];
  assign ol_now = sync_bus[4:3];
  assign ov_now = |sync_bus[6:5]; // either regulator

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  always_comb begin
    hit       = bus_sel_i & in_window(bus_addr_i);
    off       = bus_addr_i[7:0];
    wr_ctrl   = hit & bus_wr_i & (off == LSD_OFF_CTRL);
    wr_key    = hit & bus_wr_i & (off == LSD_OFF_KEY);
    rd_status = hit & ~bus_wr_i & (off == LSD_OFF_STATUS);
    ot_rise   = ot_now & ~ot_prev_reg;
    ov_rise   = ov_now & ~ov_prev_reg;
  end

  // enables are gated, not refused, except under overvoltage, so software sees what it wrote
  always_comb begin
    unlocked = (key_reg == LSD_KEY_UNLOCK);
    permit   = unlocked & ~ot_shut_reg & ~ot_now & ~ov_now &
               normal_mode_i;
    drive    = {ch_two.drive, ch_one.drive};
    status   = {ot_now, 3'b000, cl_now, ol_now & drive};
  end

  ////////////////////////////////////////////////////////////////////////////
  // register next values; hardware events beat software writes
  always_comb begin
    ctrl_next    = ctrl_reg;
    key_next     = key_reg;
    ot_shut_next = ot_shut_reg;
    ot_flag_next = ot_flag_reg;
    ov_irq_next  = ov_irq_reg;
    if (wr_ctrl) begin
      ctrl_next = bus_wdata_i & LSD_CTRL_WMASK;
    end
    if (ov_now) begin
      ctrl_next[LSD_BIT_ON_TWO] = 1'b0;
      ctrl_next[LSD_BIT_ON_ONE] = 1'b0;
    end
    if (wr_key) begin
      key_next = bus_wdata_i[3:0];
    end
    if (ov_rise) begin
      key_next = LSD_KEY_RST;
    end
    // overtemp latch released only by a control write once cool
    if (ot_now) begin
      ot_shut_next = 1'b1;
    end else if (wr_ctrl) begin
      ot_shut_next = 1'b0;
    end
    if (ot_rise & ctrl_reg[LSD_BIT_OT_IE]) begin
      ot_flag_next = 1'b1;
    end else if (rd_status) begin
      ot_flag_next = 1'b0;
    end
    if (ov_rise & regulator_overvoltage_irq_enable_i) begin
      ov_irq_next = 1'b1;
    end else if (ov_flag_read_i) begin
      ov_irq_next = 1'b0;
    end
  end

  // read data; unmapped offsets and writes return zero
  always_comb begin
    rdata_next = LSD_RDATA_RST;
    if (hit & ~bus_wr_i) begin
      case (off)
        LSD_OFF_CTRL:   rdata_next = ctrl_reg;
        LSD_OFF_STATUS: rdata_next = status;
        LSD_OFF_KEY:    rdata_next = {4'h0, key_reg};
        default:        rdata_next = LSD_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctrl_reg    <= LSD_CTRL_RST;
      key_reg     <= LSD_KEY_RST;
      ot_shut_reg <= 1'b0;
      ot_flag_reg <= 1'b0;
      ov_irq_reg  <= 1'b0;
      ot_prev_reg <= 1'b0;
      ov_prev_reg <= 1'b0;
      rdata_reg   <= LSD_RDATA_RST;
      ack_reg     <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      key_reg     <= key_next;
      ot_shut_reg <= ot_shut_next;
      ot_flag_reg <= ot_flag_next;
      ov_irq_reg  <= ov_irq_next;
      ot_prev_reg <= ot_now;
      ov_prev_reg <= ov_now;
      rdata_reg   <= rdata_next;
      ack_reg     <= bus_sel_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output stages
  assign ch_one.on     = ctrl_reg[LSD_BIT_ON_ONE];
  assign ch_one.gate   = ctrl_reg[LSD_BIT_GATE_ONE];
  assign ch_one.sel    = ctrl_reg[LSD_BIT_SEL_ONE];
  assign ch_one.permit = permit;
  assign ch_two.on     = ctrl_reg[LSD_BIT_ON_TWO];
  assign ch_two.gate   = ctrl_reg[LSD_BIT_GATE_TWO];
  assign ch_two.sel    = ctrl_reg[LSD_BIT_SEL_TWO];
  assign ch_two.permit = permit;

  lsd_channel u_ch_one (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .pwm_ch0_i (pwm_ch0_i),
    .pwm_ch1_i (pwm_ch1_i),
    .ch        (ch_one)
  );

  lsd_channel u_ch_two (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .pwm_ch0_i (pwm_ch0_i),
    .pwm_ch1_i (pwm_ch1_i),
    .ch        (ch_two)
  );

  assign drv_on_o                     = drive;
  assign bus_rdata_o                  = rdata_reg;
  assign bus_ack_o                    = ack_reg;
  assign regulator_overvoltage_flag_o = ov_now;
  assign ov_irq_o                     = ov_irq_reg;
  assign overtemp_irq_flag_o          = ot_flag_reg;
  assign irq_o                        = ot_flag_reg & low_side_irq_mask_i;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  property p_ot_ie;
    wr_ctrl |=> ctrl_reg[LSD_BIT_OT_IE] == $past(bus_wdata_i[LSD_BIT_OT_IE]);
  endproperty
  a_ot_ie: assert property (p_ot_ie) else $error("overtemp enable not stored");

  property p_sel_one;
    permit && ctrl_reg[LSD_BIT_ON_ONE] && ctrl_reg[LSD_BIT_GATE_ONE] && ctrl_reg[LSD_BIT_SEL_ONE]
      |=> drv_on_o[0] == $past(pwm_ch1_i);
  endproperty
  a_sel_one: assert property (p_sel_one) else $error("driver one wrong pwm channel");

  property p_nogate_two;
    permit && ctrl_reg[LSD_BIT_ON_TWO] && !ctrl_reg[LSD_BIT_GATE_TWO] |=> drv_on_o[1];
  endproperty
  a_nogate_two: assert property (p_nogate_two) else $error("ungated driver two not on");

  property p_locked;
    key_reg != LSD_KEY_UNLOCK |=> drv_on_o == 2'b00;
  endproperty
  a_locked: assert property (p_locked) else $error("driver on while locked");

  property p_ot_clear;
    rd_status && !(ot_rise && ctrl_reg[LSD_BIT_OT_IE]) |=> !ot_flag_reg;
  endproperty
  a_ot_clear: assert property (p_ot_clear) else $error("status read kept overtemp flag");

  property p_open_load;
    rd_status |=> bus_rdata_o[1:0] == ($past(ol_now) & $past(drive));
  endproperty
  a_open_load: assert property (p_open_load) else $error("open load shown while off");

  property p_ov_off;
    ov_now |=> ctrl_reg[LSD_BIT_ON_TWO:LSD_BIT_ON_ONE] == 2'b00 ##1 drv_on_o == 2'b00;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("overvoltage left drivers enabled");

  property p_ov_irq_cause;
    $rose(ov_irq_reg) |-> $past(ov_rise) && $past(regulator_overvoltage_irq_enable_i);
  endproperty
  a_ov_irq_cause: assert property (p_ov_irq_cause) else $error("overvoltage irq without cause");

  property p_ov_read;
    ov_flag_read_i && !ov_rise |=> !ov_irq_o;
  endproperty
  a_ov_read: assert property (p_ov_read) else $error("flag read kept overvoltage irq");

  property p_ot_rearm;
    ot_shut_reg && !ot_now && wr_ctrl |=> !ot_shut_reg;
  endproperty
  a_ot_rearm: assert property (p_ot_rearm) else $error("control write did not rearm");

  property p_sleep;
    !normal_mode_i |=> drv_on_o == 2'b00;
  endproperty
  a_sleep: assert property (p_sleep) else $error("driver on outside normal mode");

  property p_mask;
    irq_o |-> low_side_irq_mask_i && overtemp_irq_flag_o;
  endproperty
  a_mask: assert property (p_mask) else $error("irq without mask");

  c_unlock_on: cover property (wr_key && bus_wdata_i[3:0] == LSD_KEY_UNLOCK ##[1:20] drv_on_o != 2'b00);
  c_ot_cycle:  cover property ($rose(ot_shut_reg) ##[1:50] $fell(ot_shut_reg));
  c_ov_irq:    cover property ($rose(ov_irq_reg) ##[1:50] $fell(ov_irq_reg));
endmodule
`default_nettype wire

// File: lsd_mcu_model.sv
`default_nettype none
// software side of the register bus: one access every three edges
module lsd_mcu_model (
  input  wire logic        clk_sys_i,
  input  wire logic        bus_ack_i,
  input  wire logic [7:0]  bus_rdata_i,
  output logic             bus_sel_o,
  output logic             bus_wr_o,
  output logic      [15:0] bus_addr_o,
  output logic      [7:0]  bus_wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import lsd_pkg::*;
  // idle bus at time zero
  initial begin
    bus_sel_o   = 1'b0;
    bus_wr_o    = 1'b0;
    bus_addr_o  = 16'h0000;
    bus_wdata_o = 8'h00;
  end
  // released bus shows inverted values, so stale data never looks valid
  task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic ack);
    @(posedge clk_sys_i);
    bus_sel_o   <= 1'b1;
    bus_wr_o    <= wr;
    bus_addr_o  <= addr;
    bus_wdata_o <= wdata;
    @(posedge clk_sys_i);
    bus_sel_o   <= 1'b0;
    bus_addr_o  <= ~addr;
    bus_wdata_o <= ~wdata;
    // answer stands one cycle; take it at the edge that closes that cycle
    @(posedge clk_sys_i);
    rdata = bus_rdata_i;
    ack   = bus_ack_i;
  endtask
  // key write needed before driver control after reset or overvoltage
  task automatic unlock(output logic ack);
    logic [7:0] d;
    access(1'b1, LSD_BASE_BLOCKING | LSD_OFF_KEY, {4'h0, LSD_KEY_UNLOCK}, d, ack);
  endtask
endmodule
`default_nettype wire

// File: tb_low_side_driver_control.sv
`default_nettype none
module tb_low_side_driver_control;
  timeunit 1ns;
  timeprecision 100ps;
  import lsd_pkg::*;
  localparam logic [15:0] A_CTRL  = LSD_BASE_BLOCKING | LSD_OFF_CTRL;
  localparam logic [15:0] A_STAT  = LSD_BASE_BLOCKING | LSD_OFF_STATUS;
  localparam logic [15:0] A_KEY   = LSD_BASE_BLOCKING | LSD_OFF_KEY;
  localparam logic [15:0] NB_CTRL = LSD_BASE_NONBLOCKING | LSD_OFF_CTRL;
  localparam logic [15:0] NB_STAT = LSD_BASE_NONBLOCKING | LSD_OFF_STATUS;
  localparam logic [15:0] NB_KEY  = LSD_BASE_NONBLOCKING | LSD_OFF_KEY;
  logic        clk_sys_i = 1'b0;
  logic        reset_i, bus_sel, bus_wr, bus_ack, normal, pwm0, pwm1;
  logic        ov_ie, ov_rd, mask, ot_pin, ov_flag, ov_irq, ot_flag, irq, k;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata;
  logic [1:0]  cl_pin, ol_pin, ov_pin, drv_on;
  logic [2:0]  sel_code;
  int          bad_count = 0;
  int          check_count = 0;
  // 100 MHz system clock
  always #5 clk_sys_i = ~clk_sys_i;
  lsd_top lsd_top_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus_sel_i(bus_sel), .bus_wr_i(bus_wr),
    .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata), .bus_rdata_o(bus_rdata), .bus_ack_o(bus_ack),
    .normal_mode_i(normal), .pwm_ch0_i(pwm0), .pwm_ch1_i(pwm1),
    .regulator_overvoltage_irq_enable_i(ov_ie), .ov_flag_read_i(ov_rd),
    .low_side_irq_mask_i(mask), .overtemp_pin_i(ot_pin), .current_limit_pin_i(cl_pin),
    .open_load_pin_i(ol_pin), .overvolt_pin_i(ov_pin), .drv_on_o(drv_on),
    .regulator_overvoltage_flag_o(ov_flag), .ov_irq_o(ov_irq),
    .overtemp_irq_flag_o(ot_flag), .irq_o(irq));
  lsd_mcu_model lsd_mcu_model_i (
    .clk_sys_i(clk_sys_i), .bus_ack_i(bus_ack), .bus_rdata_i(bus_rdata), .bus_sel_o(bus_sel),
    .bus_wr_o(bus_wr), .bus_addr_o(bus_addr), .bus_wdata_o(bus_wdata));
  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // every access must be acknowledged, even out of window
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       ka;
    lsd_mcu_model_i.access(1'b1, a, d, r, ka);
    chk("write ack", 8'h01, {7'h00, ka});
  endtask
  task automatic rd(input string what, input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic       ka;
    lsd_mcu_model_i.access(1'b0, a, 8'h00, r, ka);
    chk("read ack", 8'h01, {7'h00, ka});
    chk(what, exp, r);
  endtask
  // outputs are read at the edge, before it updates them; pins need four edges
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic drv(input logic [1:0] exp);
    chk("drv_on", {6'h00, exp}, {6'h00, drv_on});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog, generous against roughly 175 cycles of tests
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    reset_i = 1'b1;
    normal  = 1'b1;
    pwm0    = 1'b0;
    pwm1    = 1'b0;
    ov_ie   = 1'b1;
    ov_rd   = 1'b0;
    mask    = 1'b1;
    ot_pin  = 1'b0;
    cl_pin  = 2'b00;
    ol_pin  = 2'b00;
    ov_pin  = 2'b00;
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd("ctrl reset", A_CTRL, 8'h00);
    rd("status reset", A_STAT, 8'h00);
    rd("key reset", A_KEY, 8'h00);
    // enables are stored while locked but must not drive
    wr(A_CTRL, 8'h03);
    settle(2);
    drv(2'b00);
    wr(A_KEY, 8'h03);
    settle(2);
    drv(2'b00);
    wr(NB_KEY, 8'hf5);
    settle(2);
    drv(2'b11);
    rd("key upper", A_KEY, 8'h05);
    wr(16'h0430, 8'h00);
    rd("ctrl stray", NB_CTRL, 8'h03);
    rd("unmapped", 16'h0233, 8'h00);
    wr(A_CTRL, 8'hff);
    rd("ctrl bit6", A_CTRL, 8'hbf);
    // channel 1 high, channel 0 low: selection shows at the output
    @(posedge clk_sys_i);
    pwm1 <= 1'b1;
    for (sel_code = 3'd0; sel_code < 3'd4; sel_code++) begin
      wr(A_CTRL, {2'b00, sel_code[1:0], 4'hf});
      settle(2);
      drv(sel_code[1:0]);
    end
    // swapped levels: channel 0 must reach a driver that selects it
    pwm0 <= 1'b1;
    pwm1 <= 1'b0;
    settle(2);
    drv(2'b00);
    wr(A_CTRL, 8'h0f);
    settle(2);
    drv(2'b11);
    pwm0 <= 1'b0;
    @(posedge clk_sys_i);
    normal <= 1'b0;
    settle(2);
    drv(2'b00);
    normal <= 1'b1;
    // status bits; open load hidden on a driver that is off
    wr(A_CTRL, 8'h03);
    cl_pin <= 2'b10;
    ol_pin <= 2'b11;
    settle(4);
    rd("status", A_STAT, 8'h0b);
    wr(A_STAT, 8'hff);
    wr(A_CTRL, 8'h01);
    settle(2);
    rd("status off", NB_STAT, 8'h09);
    cl_pin <= 2'b00;
    ol_pin <= 2'b00;
    // overtemperature shutdown, flag, mask and re-enable
    wr(A_CTRL, 8'h83);
    ot_pin <= 1'b1;
    settle(4);
    drv(2'b00);
    chk("ot flag", 8'h01, {7'h00, ot_flag});
    chk("irq", 8'h01, {7'h00, irq});
    mask <= 1'b0;
    settle(1);
    chk("irq masked", 8'h00, {7'h00, irq});
    mask <= 1'b1;
    rd("status ot", A_STAT, 8'h80);
    settle(1);
    chk("ot flag read", 8'h00, {7'h00, ot_flag});
    ot_pin <= 1'b0;
    settle(4);
    drv(2'b00);
    wr(A_CTRL, 8'h83);
    settle(2);
    drv(2'b11);
    // regulator overvoltage: shutdown, bits cleared and held, irq
    ov_pin <= 2'b01;
    settle(4);
    drv(2'b00);
    chk("ov flag", 8'h01, {7'h00, ov_flag});
    chk("ov irq", 8'h01, {7'h00, ov_irq});
    rd("ctrl ov", A_CTRL, 8'h80);
    wr(A_CTRL, 8'h83);
    rd("ctrl held", A_CTRL, 8'h80);
    rd("key ov", A_KEY, 8'h00);
    ov_rd <= 1'b1;
    @(posedge clk_sys_i);
    ov_rd <= 1'b0;
    settle(1);
    chk("ov irq read", 8'h00, {7'h00, ov_irq});
    ov_pin <= 2'b00;
    settle(4);
    chk("ov flag gone", 8'h00, {7'h00, ov_flag});
    lsd_mcu_model_i.unlock(k);
    chk("unlock ack", 8'h01, {7'h00, k});
    wr(A_CTRL, 8'h03);
    settle(2);
    drv(2'b11);
    // no irq while disabled, a fresh rise with enable raises it
    ov_ie  <= 1'b0;
    ov_pin <= 2'b10;
    settle(4);
    chk("ov irq off", 8'h00, {7'h00, ov_irq});
    ov_pin <= 2'b00;
    settle(4);
    ov_ie  <= 1'b1;
    ov_pin <= 2'b10;
    settle(4);
    chk("ov irq again", 8'h01, {7'h00, ov_irq});
    tally_and_finish();
  end
endmodule
`default_nettype wire
